// >>> common/rfd_pkg.sv
// Summary of operation
// - 4-bit phase code, 22.5 degree steps
// - host sends only even codes in divide-by-four
// - lo from divide-by-m counter, m 4/8/16
// - decimator takes adc or test waveform
// - host enables decimator above 65 msps
// - 32 profiles of 64 bits, 5-bit index
// - profile memory 0xF00-0xFFF, reads streamed only
// - msb-first stream addresses profile's highest byte
// - index write copies profile into buffer
// - profile load takes four cycles after index
// - memory writes spare buffer; index always reloads
// - profile fields: rsvd, bypass, start, rsvd, stop
// - power-up delay counts clocks from trigger
// - power-down delay; all ones runs continuously
// - test waveform needs global and channel enable
// - subtract dc offset unless bypass field set
// - decimating fir, two bands, 11-sample fill
// - consumer drops iir settling samples
// - global hpf bypass overrides profile flag
// - waveform is offset plus scaled sine
// - channel id word: addr, channel, zero, ramp
// - idle until trigger falls or software trigger
// - idle on trigger rise, index write without software trigger, stop expiry
package rfd_pkg;
  // device register byte addresses
  localparam logic [11:0] ADDR_PHASE    = 12'h02D;
  localparam logic [11:0] ADDR_DIV      = 12'h02E;
  localparam logic [11:0] ADDR_INDEX    = 12'h10C;
  localparam logic [11:0] ADDR_DC_BYP   = 12'h10F;
  localparam logic [11:0] ADDR_DC_LO    = 12'h110;
  localparam logic [11:0] ADDR_DC_HI    = 12'h111;
  localparam logic [11:0] ADDR_HPF      = 12'h113;
  localparam logic [11:0] ADDR_WAVE_N   = 12'h117;
  localparam logic [11:0] ADDR_WAVE_X   = 12'h118;
  localparam logic [11:0] ADDR_WAVE_C   = 12'h119;
  localparam logic [11:0] ADDR_TEST_CH  = 12'h11A;
  localparam logic [11:0] ADDR_TEST_GL  = 12'h11B;
  localparam logic [3:0]  MEM_PAGE      = 4'hF;
  localparam logic [2:0]  PROF_TOP_BYTE = 3'h7;
  // field positions
  localparam int SWTRIG_BIT = 5;
  localparam int HPF_BIT    = 5;
  localparam int BAND_BIT   = 0;
  localparam int TEST_EN    = 0;
  localparam int TEST_CHID  = 1;
  localparam int RUN_BIT    = 6;
  localparam int LOAD_BIT   = 7;
  localparam int PROF_BYP   = 31;
  localparam int START_LSB  = 16;
  localparam logic [2:0]  LOAD_CYCLES = 3'h4;
  localparam logic [14:0] STOP_CONT   = 15'h7FFF;
  localparam logic [3:0]  FILL_SAMPLES = 4'hB;
  localparam int FIR_TAPS  = 11;
  localparam int FIR_SHIFT = 6;
  localparam int IIR_SHIFT = 6;
  // divider select codes and accumulator steps
  localparam logic [1:0] DIV_4  = 2'h0;
  localparam logic [1:0] DIV_8  = 2'h1;
  localparam logic [3:0] STEP_4  = 4'h4;
  localparam logic [3:0] STEP_8  = 4'h2;
  localparam logic [3:0] STEP_16 = 4'h1;
  localparam logic [3:0] QUARTER = 4'h4;
  localparam logic signed [7:0] FIR_LB [FIR_TAPS] = '{-8'sd1, 8'sd0, 8'sd4, 8'sd9, 8'sd13,
    8'sd14, 8'sd13, 8'sd9, 8'sd4, 8'sd0, -8'sd1};
  localparam logic signed [7:0] FIR_HB [FIR_TAPS] = '{8'sd1, -8'sd2, -8'sd3, 8'sd6, 8'sd19,
    8'sd22, 8'sd19, 8'sd6, -8'sd3, -8'sd2, 8'sd1};
  // host register word addresses and command ops
  localparam logic [1:0] HREG_CMD    = 2'h0;
  localparam logic [1:0] HREG_STATUS = 2'h1;
  localparam logic [1:0] HREG_DLO    = 2'h2;
  localparam logic [1:0] HREG_DHI    = 2'h3;
  localparam logic [1:0] OP_WR  = 2'h0;
  localparam logic [1:0] OP_RD  = 2'h1;
  localparam logic [1:0] OP_SWR = 2'h2;
  localparam logic [1:0] OP_SRD = 2'h3;
  localparam logic [2:0] STREAM_LAST = 3'h7;
  typedef enum logic {ST_IDLE = 1'b0, ST_RUN = 1'b1} rfd_pwr_t;
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_XFER = 2'b01, H_RDW = 2'b10,
    H_LOAD = 2'b11} rfd_host_t;
endpackage

// >>> common/rfd_link_if.sv
`timescale 1ns/10ps
interface rfd_link_if;
  logic        cfg_wr;
  logic        cfg_rd;
  logic [11:0] cfg_addr;
  logic [7:0]  cfg_wdata;
  logic [7:0]  cfg_rdata;
  logic        cfg_rvalid;
  logic        transmit_trigger;
  modport dev (input cfg_wr, cfg_rd, cfg_addr, cfg_wdata, transmit_trigger,
               output cfg_rdata, cfg_rvalid);
  modport host (output cfg_wr, cfg_rd, cfg_addr, cfg_wdata, transmit_trigger,
                input cfg_rdata, cfg_rvalid);
endinterface

// >>> logic/rfd_device.sv
`timescale 1ns/10ps
module rfd_device #(
  parameter logic [2:0] CHANNEL = 3'h0
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_srst,
  rfd_link_if.dev          link,
  input  wire logic [13:0] i_adc_data,
  input  wire logic [4:0]  i_chip_addr,
  output logic      [15:0] o_data,
  output logic             o_data_valid,
  output logic             o_lo_i,
  output logic             o_lo_q,
  output logic             o_chan_power,
  output logic             o_running
);
  // saturate a wide signed value to the 14-bit sample range
  function automatic logic signed [13:0] sat14(input logic signed [23:0] v);
    if (v > 24'sd8191)
      return 14'sh1FFF;
    else if (v < -24'sd8192)
      return 14'sh2000;
    else
      return v[13:0];
  endfunction

  // quarter-wave sine, 64 points per period
  function automatic logic signed [13:0] sine64(input logic [5:0] ph);
    logic [4:0]  q;
    logic [12:0] m;
    q = ph[4] ? 5'(5'h10 - {1'b0, ph[3:0]}) : {1'b0, ph[3:0]};
    case (q)
      5'h00: m = 13'h0000; 5'h01: m = 13'h0323; 5'h02: m = 13'h063E;
      5'h03: m = 13'h094A; 5'h04: m = 13'h0C3F; 5'h05: m = 13'h0F15;
      5'h06: m = 13'h11C7; 5'h07: m = 13'h144D; 5'h08: m = 13'h16A0;
      5'h09: m = 13'h18BC; 5'h0A: m = 13'h1A9B; 5'h0B: m = 13'h1C38;
      5'h0C: m = 13'h1D90; 5'h0D: m = 13'h1E9F; 5'h0E: m = 13'h1F63;
      5'h0F: m = 13'h1FD9;
      default: m = 13'h1FFF;
    endcase
    return ph[5] ? -$signed({1'b0, m}) : $signed({1'b0, m});
  endfunction

  logic [3:0]  phase_reg;
  logic [1:0]  div_reg;
  logic [4:0]  index_reg;
  logic [2:0]  dc_byp_reg;
  logic [15:0] dc_off_reg;
  logic [7:0]  hpf_cfg_reg;
  logic [5:0]  wave_n_reg;
  logic [3:0]  wave_x_reg;
  logic [7:0]  wave_c_reg;
  logic [7:0]  test_ch_reg;
  logic [1:0]  test_gl_reg;
  logic [63:0] prof_mem [32];
  logic [63:0] cur_prof_reg;
  logic [2:0]  load_cnt_reg;
  logic [7:0]  rdata_reg;
  logic        rvalid_reg;

  // register write strobes
  wire logic       wr        = link.cfg_wr;
  wire logic [7:0] wd        = link.cfg_wdata;
  wire logic       mem_hit   = link.cfg_addr[11:8] == rfd_pkg::MEM_PAGE;
  wire logic       wr_mem    = wr && mem_hit;
  wire logic       wr_index  = wr && link.cfg_addr == rfd_pkg::ADDR_INDEX;
  wire logic       sw_trig   = wr_index && wd[rfd_pkg::SWTRIG_BIT];
  wire logic [4:0] mem_row   = link.cfg_addr[7:3];
  wire logic [5:0] mem_lsb   = {link.cfg_addr[2:0], 3'h0};

  // config registers; each setting lands on a single byte write except the dc offset, which takes two
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      phase_reg   <= 4'h0;
      div_reg     <= 2'h0;
      index_reg   <= 5'h00;
      dc_byp_reg  <= 3'h0;
      dc_off_reg  <= 16'h0000;
      hpf_cfg_reg <= 8'h00;
      wave_n_reg  <= 6'h00;
      wave_x_reg  <= 4'h0;
      wave_c_reg  <= 8'h00;
      test_ch_reg <= 8'h00;
      test_gl_reg <= 2'h0;
    end else if (wr) begin
      case (link.cfg_addr)
        rfd_pkg::ADDR_PHASE:   phase_reg   <= wd[3:0];
        rfd_pkg::ADDR_DIV:     div_reg     <= wd[2:1];
        rfd_pkg::ADDR_INDEX:   index_reg   <= wd[4:0];
        rfd_pkg::ADDR_DC_BYP:  dc_byp_reg  <= wd[2:0];
        rfd_pkg::ADDR_DC_LO:   dc_off_reg[7:0]  <= wd;
        rfd_pkg::ADDR_DC_HI:   dc_off_reg[15:8] <= wd;
        rfd_pkg::ADDR_HPF:     hpf_cfg_reg <= wd;
        rfd_pkg::ADDR_WAVE_N:  wave_n_reg  <= wd[5:0];
        rfd_pkg::ADDR_WAVE_X:  wave_x_reg  <= wd[3:0];
        rfd_pkg::ADDR_WAVE_C:  wave_c_reg  <= wd;
        rfd_pkg::ADDR_TEST_CH: test_ch_reg <= wd;
        rfd_pkg::ADDR_TEST_GL: test_gl_reg <= wd[1:0];
        default: ;
      endcase
    end
  end

  // profile memory, byte-wide writes; the buffer is untouched here
  always_ff @(posedge i_sys_clk) begin
    if (wr_mem)
      prof_mem[mem_row][mem_lsb +: 8] <= wd;
  end

  // profile load: every index write restarts it, same index or not
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      load_cnt_reg <= 3'h0;
      cur_prof_reg <= 64'h0;
    end else if (wr_index) begin
      load_cnt_reg <= rfd_pkg::LOAD_CYCLES;
    end else if (load_cnt_reg != 3'h0) begin
      load_cnt_reg <= load_cnt_reg - 3'h1;
      if (load_cnt_reg == 3'h1)
        cur_prof_reg <= prof_mem[index_reg];
    end
  end

  // profile fields
  wire logic        prof_byp   = cur_prof_reg[rfd_pkg::PROF_BYP];
  wire logic [14:0] prof_start = cur_prof_reg[rfd_pkg::START_LSB +: 15];
  wire logic [14:0] prof_stop  = cur_prof_reg[14:0];

  // trigger pin synchroniser and edge detect
  logic trig_s1_reg;
  logic trig_s2_reg;
  logic trig_d_reg;
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      trig_s1_reg <= 1'b1;
      trig_s2_reg <= 1'b1;
      trig_d_reg  <= 1'b1;
    end else begin
      trig_s1_reg <= link.transmit_trigger;
      trig_s2_reg <= trig_s1_reg;
      trig_d_reg  <= trig_s2_reg;
    end
  end
  wire logic trig_fall = trig_d_reg && !trig_s2_reg;
  wire logic trig_rise = !trig_d_reg && trig_s2_reg;

  // power scheme; a software trigger outranks the idle of the same write
  rfd_pkg::rfd_pwr_t state_reg;
  rfd_pkg::rfd_pwr_t state_next;
  logic [15:0]       dly_reg;
  wire logic is_run   = state_reg == rfd_pkg::ST_RUN;
  wire logic stop_on  = prof_stop != rfd_pkg::STOP_CONT;
  wire logic expired  = is_run && stop_on && dly_reg >= {1'b0, prof_stop};
  wire logic pwr_on   = is_run && dly_reg >= {1'b0, prof_start} && !expired;
  always_comb begin
    case (state_reg)
      rfd_pkg::ST_IDLE:
        state_next = (trig_fall || sw_trig) ? rfd_pkg::ST_RUN : rfd_pkg::ST_IDLE;
      rfd_pkg::ST_RUN:
        state_next = (trig_rise || (wr_index && !sw_trig) || expired) ?
                     rfd_pkg::ST_IDLE : rfd_pkg::ST_RUN;
      default: state_next = rfd_pkg::ST_IDLE;
    endcase
  end

  // delay counter restarts on each trigger fall and saturates
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_reg <= rfd_pkg::ST_IDLE;
      dly_reg   <= 16'h0000;
    end else begin
      state_reg <= state_next;
      if (trig_fall || sw_trig)
        dly_reg <= 16'h0000;
      else if (is_run && dly_reg != 16'hFFFF)
        dly_reg <= dly_reg + 16'h0001;
    end
  end

  // register read-back; the memory answers any read, streamed or not
  wire logic [7:0] stat_byte = {(load_cnt_reg != 3'h0), is_run, 1'b0, index_reg};
  wire logic [7:0] mem_byte  = prof_mem[mem_row][mem_lsb +: 8];
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= link.cfg_rd;
      if (link.cfg_rd)
        rdata_reg <= mem_hit ? mem_byte :
                     link.cfg_addr == rfd_pkg::ADDR_INDEX ? stat_byte : 8'h00;
    end
  end
  assign link.cfg_rdata  = rdata_reg;
  assign link.cfg_rvalid = rvalid_reg;

  // lo divider: phase accumulator steps 16/m per clock
  logic [3:0] lo_acc_reg;
  wire logic [3:0] lo_step = div_reg == rfd_pkg::DIV_4 ? rfd_pkg::STEP_4 :
                             div_reg == rfd_pkg::DIV_8 ? rfd_pkg::STEP_8 : rfd_pkg::STEP_16;
  wire logic [3:0] lo_ph   = 4'(lo_acc_reg + phase_reg);
  wire logic [3:0] lo_phq  = 4'(lo_ph + rfd_pkg::QUARTER);

  // test waveform: offset plus sine scaled by a power of two
  logic [5:0] wave_ph_reg;
  wire logic signed [13:0] wave_c   = 14'({6'h00, wave_c_reg[3:0]} << wave_c_reg[7:4]);
  wire logic signed [13:0] wave_s   = sine64(wave_ph_reg) >>> wave_x_reg;
  wire logic signed [13:0] wave     = sat14(24'(wave_c) + 24'(wave_s));
  wire logic               test_on  = test_gl_reg[rfd_pkg::TEST_EN] && test_ch_reg[CHANNEL];
  wire logic signed [13:0] src      = test_on ? wave : $signed(i_adc_data);
  wire logic signed [13:0] dc_cor   = (dc_byp_reg != 3'h0) ? src :
                             sat14(24'(src) - 24'($signed(dc_off_reg[13:0])));

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      lo_acc_reg  <= 4'h0;
      wave_ph_reg <= 6'h00;
    end else begin
      lo_acc_reg  <= 4'(lo_acc_reg + lo_step);
      wave_ph_reg <= 6'(wave_ph_reg + wave_n_reg);
    end
  end

  // decimating fir; held in reset while idle to save power
  logic signed [13:0] tap_reg [rfd_pkg::FIR_TAPS];
  logic [3:0]         fill_reg;
  logic               dec_ph_reg;
  logic signed [23:0] fir_acc;
  always_comb begin
    fir_acc = 24'sh000000;
    for (int k = 0; k < rfd_pkg::FIR_TAPS; k++)
      fir_acc = fir_acc + 24'(tap_reg[k]) * 24'(hpf_cfg_reg[rfd_pkg::BAND_BIT] ?
                rfd_pkg::FIR_HB[k] : rfd_pkg::FIR_LB[k]);
  end
  wire logic fir_vld = dec_ph_reg && fill_reg == rfd_pkg::FILL_SAMPLES;
  wire logic signed [13:0] fir_out = sat14(fir_acc >>> rfd_pkg::FIR_SHIFT);

  always_ff @(posedge i_sys_clk) begin
    if (i_srst || !is_run) begin
      fill_reg   <= 4'h0;
      dec_ph_reg <= 1'b0;
      for (int k = 0; k < rfd_pkg::FIR_TAPS; k++)
        tap_reg[k] <= 14'sh0000;
    end else begin
      tap_reg[0] <= dc_cor;
      for (int k = 1; k < rfd_pkg::FIR_TAPS; k++)
        tap_reg[k] <= tap_reg[k - 1];
      dec_ph_reg <= !dec_ph_reg;
      if (fill_reg != rfd_pkg::FILL_SAMPLES)
        fill_reg <= fill_reg + 4'h1;
    end
  end

  // two cascaded dc blockers make the second-order high-pass
  logic signed [23:0] x1_reg;
  logic signed [23:0] y1_reg;
  logic signed [23:0] y2_reg;
  wire logic               hpf_on = !hpf_cfg_reg[rfd_pkg::HPF_BIT] && !prof_byp;
  wire logic signed [23:0] y1_n   = 24'(fir_out) - x1_reg + y1_reg - (y1_reg >>> rfd_pkg::IIR_SHIFT);
  wire logic signed [23:0] y2_n   = y1_n - y1_reg + y2_reg - (y2_reg >>> rfd_pkg::IIR_SHIFT);
  wire logic signed [13:0] filt   = hpf_on ? sat14(y2_n) : fir_out;
  logic [6:0] ramp_reg;
  wire logic [15:0] chid_word = {i_chip_addr, CHANNEL, 1'b0, ramp_reg};

  always_ff @(posedge i_sys_clk) begin
    if (i_srst || !is_run) begin
      x1_reg <= 24'sh000000;
      y1_reg <= 24'sh000000;
      y2_reg <= 24'sh000000;
    end else if (fir_vld) begin
      x1_reg <= 24'(fir_out);
      y1_reg <= y1_n;
      y2_reg <= y2_n;
    end
  end

  // outputs, all registered
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_data       <= 16'h0000;
      o_data_valid <= 1'b0;
      ramp_reg     <= 7'h00;
      o_lo_i       <= 1'b0;
      o_lo_q       <= 1'b0;
      o_chan_power <= 1'b0;
      o_running    <= 1'b0;
    end else begin
      o_data_valid <= is_run && fir_vld;
      if (is_run && fir_vld) begin
        o_data   <= test_gl_reg[rfd_pkg::TEST_CHID] ? chid_word : 16'(filt);
        ramp_reg <= ramp_reg + 7'h01;
      end
      o_lo_i       <= lo_ph[3];
      o_lo_q       <= lo_phq[3];
      o_chan_power <= pwr_on;
      o_running    <= is_run;
    end
  end
endmodule

// >>> logic/rfd_host.sv
`timescale 1ns/10ps
module rfd_host (
  input  wire logic        i_sys_clk,
  input  wire logic        i_srst,
  rfd_link_if.host         link,
  input  wire logic [1:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_tx_trigger
);
  rfd_pkg::rfd_host_t st_reg;
  logic [1:0]  op_reg;
  logic [11:0] addr_reg;
  logic [7:0]  byte_reg;
  logic [63:0] data_reg;
  logic [2:0]  cnt_reg;
  logic [1:0]  div_shadow_reg;
  logic        err_phase_reg;
  logic        err_rd_reg;
  logic        wr_o_reg;
  logic        rd_o_reg;
  logic [11:0] addr_o_reg;
  logic [7:0]  wdata_o_reg;
  logic        trig_reg;

  // bus decode; the command register stalls while a transfer runs
  wire logic busy    = st_reg != rfd_pkg::H_IDLE;
  wire logic req     = i_avs_read || i_avs_write;
  wire logic cmd_wr  = i_avs_write && i_avs_address == rfd_pkg::HREG_CMD;
  wire logic take    = req && !o_avs_waitrequest;
  wire logic go      = take && cmd_wr;
  wire logic [1:0]  c_op   = i_avs_writedata[21:20];
  wire logic [11:0] c_addr = i_avs_writedata[11:0];
  wire logic [7:0]  c_data = i_avs_writedata[19:12];
  wire logic c_mem   = c_addr[11:8] == rfd_pkg::MEM_PAGE;
  wire logic bad_ph  = c_op == rfd_pkg::OP_WR && c_addr == rfd_pkg::ADDR_PHASE &&
                       div_shadow_reg == rfd_pkg::DIV_4 && c_data[0];
  wire logic bad_rd  = c_op == rfd_pkg::OP_RD && c_mem;
  wire logic [11:0] s_addr = {addr_reg[11:3], 3'(rfd_pkg::PROF_TOP_BYTE - cnt_reg)};
  wire logic [7:0]  s_byte = data_reg[6'(8 * (rfd_pkg::PROF_TOP_BYTE - cnt_reg)) +: 8];
  wire logic [31:0] rd_mux = i_avs_address == rfd_pkg::HREG_STATUS ?
                             {21'h0, err_rd_reg, err_phase_reg, busy, byte_reg} :
                             i_avs_address == rfd_pkg::HREG_DLO ? data_reg[31:0] :
                             i_avs_address == rfd_pkg::HREG_DHI ? data_reg[63:32] : 32'h0;

  // slave handshake: waitrequest drops for one cycle per access
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0;
      trig_reg          <= 1'b1;
    end else begin
      o_avs_waitrequest <= !(req && o_avs_waitrequest && !(cmd_wr && busy));
      if (req && o_avs_waitrequest)
        o_avs_readdata <= rd_mux;
      trig_reg <= i_tx_trigger;
    end
  end

  // error flags; setting only happens on a command, never with a clear
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      err_phase_reg <= 1'b0;
      err_rd_reg    <= 1'b0;
    end else if (go) begin
      err_phase_reg <= err_phase_reg || bad_ph;
      err_rd_reg    <= err_rd_reg || bad_rd;
    end else if (take && i_avs_write && i_avs_address == rfd_pkg::HREG_STATUS) begin
      err_phase_reg <= 1'b0;
      err_rd_reg    <= 1'b0;
    end
  end

  // transfer sequencer
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      st_reg <= rfd_pkg::H_IDLE;
      op_reg <= rfd_pkg::OP_WR;
      addr_reg <= 12'h000;
      byte_reg <= 8'h00;
      data_reg <= 64'h0;
      cnt_reg  <= 3'h0;
      div_shadow_reg <= rfd_pkg::DIV_4;
      wr_o_reg <= 1'b0;
      rd_o_reg <= 1'b0;
      addr_o_reg  <= 12'h000;
      wdata_o_reg <= 8'h00;
    end else begin
      wr_o_reg <= 1'b0;
      rd_o_reg <= 1'b0;
      if (take && i_avs_write && i_avs_address == rfd_pkg::HREG_DLO)
        data_reg[31:0] <= i_avs_writedata;
      if (take && i_avs_write && i_avs_address == rfd_pkg::HREG_DHI)
        data_reg[63:32] <= i_avs_writedata;
      case (st_reg)
        rfd_pkg::H_IDLE: begin
          if (go && !bad_ph && !bad_rd) begin
            op_reg   <= c_op;
            addr_reg <= c_addr;
            byte_reg <= c_data;
            cnt_reg  <= 3'h0;
            st_reg   <= rfd_pkg::H_XFER;
            if (c_op == rfd_pkg::OP_WR && c_addr == rfd_pkg::ADDR_DIV)
              div_shadow_reg <= c_data[2:1];
          end
        end
        rfd_pkg::H_XFER: begin
          addr_o_reg  <= op_reg[1] ? s_addr : addr_reg;
          wdata_o_reg <= op_reg == rfd_pkg::OP_SWR ? s_byte : byte_reg;
          wr_o_reg    <= !op_reg[0];
          rd_o_reg    <= op_reg[0];
          if (op_reg[0])
            st_reg <= rfd_pkg::H_RDW;
          else if (op_reg == rfd_pkg::OP_SWR && cnt_reg != rfd_pkg::STREAM_LAST)
            cnt_reg <= cnt_reg + 3'h1;
          else begin
            cnt_reg <= 3'h0;
            st_reg  <= addr_reg == rfd_pkg::ADDR_INDEX ? rfd_pkg::H_LOAD : rfd_pkg::H_IDLE;
          end
        end
        rfd_pkg::H_RDW: begin
          if (link.cfg_rvalid) begin
            if (op_reg == rfd_pkg::OP_RD)
              byte_reg <= link.cfg_rdata;
            else
              data_reg[6'(8 * (rfd_pkg::PROF_TOP_BYTE - cnt_reg)) +: 8] <= link.cfg_rdata;
            if (op_reg == rfd_pkg::OP_SRD && cnt_reg != rfd_pkg::STREAM_LAST) begin
              cnt_reg <= cnt_reg + 3'h1;
              st_reg  <= rfd_pkg::H_XFER;
            end else
              st_reg <= rfd_pkg::H_IDLE;
          end
        end
        rfd_pkg::H_LOAD: begin
          // hold off the next command while the profile loads
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == rfd_pkg::LOAD_CYCLES)
            st_reg <= rfd_pkg::H_IDLE;
        end
        default: st_reg <= rfd_pkg::H_IDLE;
      endcase
    end
  end

  assign link.cfg_wr           = wr_o_reg;
  assign link.cfg_rd           = rd_o_reg;
  assign link.cfg_addr         = addr_o_reg;
  assign link.cfg_wdata        = wdata_o_reg;
  assign link.transmit_trigger = trig_reg;
endmodule

// >>> sim/rfd_link_properties.sv
`timescale 1ns/10ps
module rfd_link_properties (
  input wire logic        i_sys_clk,
  input wire logic        i_srst,
  input wire logic        cfg_wr,
  input wire logic        cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [7:0]  cfg_wdata,
  input wire logic [7:0]  cfg_rdata,
  input wire logic        cfg_rvalid,
  input wire logic        transmit_trigger
);
  logic [1:0] div_reg;
  logic [4:0] idx_reg;
  logic       swt_reg;
  logic [3:0] hi_reg;
  // decoded link strobes
  wire idx_wr = cfg_wr && (cfg_addr == rfd_pkg::ADDR_INDEX);
  wire idx_rd = cfg_rd && (cfg_addr == rfd_pkg::ADDR_INDEX);
  wire mem_wr = cfg_wr && (cfg_addr[11:8] == rfd_pkg::MEM_PAGE);
  // shadow of what was sent; trigger high time saturates at 15
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      div_reg <= 2'h0;
      idx_reg <= 5'h00;
      swt_reg <= 1'b0;
      hi_reg  <= 4'h0;
    end else begin
      if (cfg_wr && cfg_addr == rfd_pkg::ADDR_DIV) div_reg <= cfg_wdata[2:1];
      if (idx_wr) idx_reg <= cfg_wdata[4:0];
      if (idx_wr) swt_reg <= cfg_wdata[rfd_pkg::SWTRIG_BIT];
      hi_reg <= !transmit_trigger ? 4'h0 : (hi_reg == 4'hF ? 4'hF : hi_reg + 4'h1);
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  sequence s_quiet;
    !cfg_wr && !cfg_rd;
  endsequence
  AST_RVALID_NEXT: assert property (cfg_rd |=> cfg_rvalid)
    else $error("read not answered");
  AST_RVALID_ONLY: assert property (!cfg_rd |=> !cfg_rvalid)
    else $error("answer without read");
  AST_RDATA_HOLD: assert property (!cfg_rd |=> $stable(cfg_rdata))
    else $error("read data moved");
  AST_ODD_PHASE: assert property (cfg_wr && cfg_addr == rfd_pkg::ADDR_PHASE
    && div_reg == rfd_pkg::DIV_4 |-> !cfg_wdata[0]) else $error("odd code sent");
  AST_LOAD_QUIET: assert property (idx_wr |=> s_quiet [*4])
    else $error("strobe during load");
  AST_INDEX_RB: assert property (idx_rd |=> cfg_rdata[4:0] == idx_reg)
    else $error("index readback wrong");
  AST_IDLE_TRIG: assert property (idx_rd && hi_reg == 4'hF && !swt_reg
    |=> !cfg_rdata[rfd_pkg::RUN_BIT]) else $error("running with trigger high");
  AST_STREAM_DOWN: assert property (mem_wr && $past(mem_wr)
    |-> cfg_addr == $past(cfg_addr) - 12'h001) else $error("stream order wrong");
endmodule

// >>> sim/rf_decimator_profile_path_bench.sv
`timescale 1ns/10ps
module rf_decimator_profile_path_bench;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic        trig = 1'b1;
  logic [1:0]  adr = 2'h0;
  logic [31:0] wd = 32'h0;
  logic [13:0] adc = 14'h0;
  logic [4:0]  chip = 5'h0;
  logic [31:0] rdat, q, lo;
  logic [15:0] dout;
  logic        wt, dv, run, pwr, loi;
  integer      cyc = 0, ph0 = 0;
  logic [7:0]  regs [int];
  integer      seed = 60;
  integer      err_count = 0;
  integer      checks_done = 0;
  // clock and random samples every cycle
  always #12.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) adc <= 14'($random(seed));
  rfd_link_if link ();
  rfd_host i_rfd_host (.i_sys_clk(clk), .i_srst(srst), .link(link), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wt), .i_tx_trigger(trig));
  rfd_device i_rfd_device (.i_sys_clk(clk), .i_srst(srst), .link(link), .i_adc_data(adc),
    .i_chip_addr(chip), .o_data(dout), .o_data_valid(dv), .o_lo_i(loi), .o_lo_q(),
    .o_chan_power(pwr), .o_running(run));
  rfd_link_properties i_rfd_link_properties (.i_sys_clk(clk), .i_srst(srst),
    .cfg_wr(link.cfg_wr), .cfg_rd(link.cfg_rd), .cfg_addr(link.cfg_addr),
    .cfg_wdata(link.cfg_wdata), .cfg_rdata(link.cfg_rdata), .cfg_rvalid(link.cfg_rvalid),
    .transmit_trigger(link.transmit_trigger));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // request held until waitrequest is sampled low
  task automatic av(input logic w, input logic [1:0] a, input logic [31:0] d);
    @(posedge clk);
    {wr, rd, adr, wd} <= {w, !w, a, d};
    do @(posedge clk); while (wt !== 1'b0);
    q = rdat;
    {wr, rd} <= 2'b00;
  endtask
  // status polled until not busy; polls are not bounded
  task automatic cmd(input logic [1:0] op, input logic [11:0] a, input logic [7:0] d);
    av(1'b1, rfd_pkg::HREG_CMD, {10'h000, op, d, a});
    do av(1'b0, rfd_pkg::HREG_STATUS, 32'h0); while (q[8] !== 1'b0);
  endtask
  task automatic reg_rw(input logic [11:0] a, input logic [7:0] d);
    regs[a] = 8'h00; // settings other than the index read back as zero
    cmd(rfd_pkg::OP_WR, a, d);
    cmd(rfd_pkg::OP_RD, a, 8'h00);
    check(q[7:0], regs[a]);
  endtask
  // stream write, clear the data words, stream read back
  task automatic prof(input logic [4:0] p, input logic [63:0] d);
    av(1'b1, rfd_pkg::HREG_DLO, d[31:0]);
    av(1'b1, rfd_pkg::HREG_DHI, d[63:32]);
    cmd(rfd_pkg::OP_SWR, {4'hF, p, 3'h7}, 8'h00);
    av(1'b1, rfd_pkg::HREG_DLO, 32'h0);
    av(1'b1, rfd_pkg::HREG_DHI, 32'h0);
    cmd(rfd_pkg::OP_SRD, {4'hF, p, 3'h7}, 8'h00);
    av(1'b0, rfd_pkg::HREG_DLO, 32'h0);
    lo = q;
    av(1'b0, rfd_pkg::HREG_DHI, 32'h0);
    check({q, lo}, d);
  endtask
  task automatic wait_run(input logic e);
    for (int n = 0; n < 30 && run !== e; n++) @(posedge clk);
    check(run, e);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog: whole run needs far fewer cycles than this
  initial begin
    #2000000;
    err_count++;
    finish_test;
  end
  initial begin
    chip = 5'($random(seed));
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    reg_rw(rfd_pkg::ADDR_DC_LO, 8'($random(seed)));
    cmd(rfd_pkg::OP_RD, 12'h000, 8'h00);
    check(q[10:0], 11'h000);
    $display("registers done");
    // odd code refused in divide-by-four, every code kept in divide-by-16
    reg_rw(rfd_pkg::ADDR_DIV, 8'h00);
    reg_rw(rfd_pkg::ADDR_PHASE, 8'h02);
    cmd(rfd_pkg::OP_WR, rfd_pkg::ADDR_PHASE, 8'h03);
    cmd(rfd_pkg::OP_RD, rfd_pkg::ADDR_PHASE, 8'h00);
    check(q[9:0], 10'h200);
    reg_rw(rfd_pkg::ADDR_DIV, 8'h04);
    // lo rises one clock earlier per code step in divide-by-16
    for (int c = 0; c < 16; c++) begin
      reg_rw(rfd_pkg::ADDR_PHASE, 8'(c));
      do @(posedge clk); while (loi);
      do @(posedge clk); while (!loi);
      if (c == 0) ph0 = cyc % 16;
      check((cyc + c) % 16, ph0);
    end
    $display("phase codes done");
    // memory is never read by a single access
    cmd(rfd_pkg::OP_RD, 12'hF00, 8'h00);
    check(q[10], 1'b1);
    av(1'b1, rfd_pkg::HREG_STATUS, 32'h0);
    prof(5'h00, {$random(seed), $random(seed)});
    prof(5'h1F, {$random(seed), $random(seed)});
    prof(5'h03, {32'h0, 1'b0, 15'h0000, 1'b0, rfd_pkg::STOP_CONT});
    $display("profiles done");
    // load profile 3, channel id words while running from a trigger fall
    cmd(rfd_pkg::OP_WR, rfd_pkg::ADDR_INDEX, 8'h03);
    cmd(rfd_pkg::OP_RD, rfd_pkg::ADDR_INDEX, 8'h00);
    check(q[7:0], 8'h03);
    reg_rw(rfd_pkg::ADDR_TEST_CH, 8'h01);
    reg_rw(rfd_pkg::ADDR_TEST_GL, 8'h03);
    trig <= 1'b0;
    wait_run(1'b1);
    repeat (4) @(posedge clk);
    check(pwr, 1'b1);
    for (int n = 0; n < 100 && dv !== 1'b1; n++) @(posedge clk);
    check({dv, dout[15:7]}, {1'b1, chip, 4'h0});
    repeat (2) @(posedge clk);
    check(dv, 1'b1);
    trig <= 1'b1;
    wait_run(1'b0);
    // software trigger, then idle by writing the same index again
    cmd(rfd_pkg::OP_WR, rfd_pkg::ADDR_INDEX, 8'h23);
    wait_run(1'b1);
    cmd(rfd_pkg::OP_WR, rfd_pkg::ADDR_INDEX, 8'h03);
    wait_run(1'b0);
    $display("power scheme done");
    finish_test;
  end
endmodule
